// ===== core/cpi_core.sv
/*
  Channel program instruction unit: increments, host interrupt, soft clear, relative
  and vectored jumps and calls, and bit tests, driven by software over APB.
  Assumes an APB master on pclk and a host that services host_irq.
*/
// Function
// - add_one_table adds one to the named line_table entry and writes it back.
// - add_one_indexed increments the entry selected by index_hold; takes 1.0 us.
// - Accumulator increment adds one to main_acc in place; takes 0.38 us.
// - add_one_index_reg increments index_hold in place; takes 0.38 us.
// - add_one_local_store increments local store at entry:index_hold; takes 7.0 us.
// - add_one_local_store is illegal unless channel_config_a bit 4 is set.
// - Increments set carry flag on carry out, and top bit and zero from result.
// - host_interrupt_op interrupts the host unless the level is 0; flags unchanged.
// - soft_clear_all clears adapters, internal registers and entries 8, 9, 40, 41.
// - After soft_clear_all all processor lines stop for dumping.
// - call_relative pushes location plus one, drops stack_top twice, jumps; 6.2 us.
// - Relative displacements are signed 16-bit, from the operand byte address.
// - call_vector pushes the return pointer and jumps to the entry's 16-bit pointer.
// - branch_relative adds the displacement without touching the stack; 3.0 us.
// - branch_vector loads the 16-bit pointer from the entry, saving nothing.
// - bit_test_table ANDs operand with entry, sets top bit and zero flags (carry kept), discards; 1.2 us.
// - bit_test_indexed ANDs operand with entry at index_hold, sets top bit and zero flags (carry kept); 0.25 us.
// - Jumps, calls and host_interrupt_op leave all three flags unchanged.
`timescale 1ns/1ps
`include "cpi_cfg.svh"

module cpi_core
  import cpi_pkg::*;
#(
  parameter int LT_AW = 6,
  parameter int LS_AW = 9,
  parameter int STK_AW = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host and adapters
  output logic host_irq,
  output logic adapter_clear,
  output logic lines_stopped
);

  // --------------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------------
  function automatic logic [7:0] op_cycles(input logic [7:0] op);
    unique case (op)
      `CPI_OP_INC_TBL: op_cycles = `CPI_CYC(`CPI_T_INC_TBL_NS);
      `CPI_OP_INC_IDX: op_cycles = `CPI_CYC(`CPI_T_INC_IDX_NS);
      `CPI_OP_INC_ACC, `CPI_OP_INC_B: op_cycles = `CPI_CYC(`CPI_T_INC_ACC_NS);
      `CPI_OP_INC_LS: op_cycles = `CPI_CYC(`CPI_T_INC_LS_NS);
      `CPI_OP_CALL_REL: op_cycles = `CPI_CYC(`CPI_T_CALL_REL_NS);
      `CPI_OP_JUMP_REL: op_cycles = `CPI_CYC(`CPI_T_JUMP_REL_NS);
      `CPI_OP_BIT_TBL: op_cycles = `CPI_CYC(`CPI_T_BIT_TBL_NS);
      `CPI_OP_BIT_IDX: op_cycles = `CPI_CYC(`CPI_T_BIT_IDX_NS);
      default: op_cycles = `CPI_CYC(`CPI_T_OTHER_NS);
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `CPI_A_LSDATA);
  endfunction

  // --------------------------------------------------------------------------
  // State and storage
  // --------------------------------------------------------------------------
  cpi_state_t s;
  cpi_state_t n;
  logic [7:0] op;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [15:0] disp;
  logic [7:0] stk_top_m1;
  logic apb_wr;
  logic go;
  logic [4*8-1:0] lt_rd;
  logic lt_we;
  logic [LT_AW-1:0] lt_wa;
  logic [7:0] lt_wd;
  logic [(1<<LT_AW)-1:0] lt_clr;
  logic [7:0] ls_rd;
  logic ls_we;
  logic [LS_AW-1:0] ls_wa;
  logic [7:0] ls_wd;
  logic [LS_AW-1:0] ls_ra;
  logic [15:0] stk_rd;
  logic stk_we;
  logic [15:0] stk_wd;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic alu_and;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_top;
  logic alu_z;
  logic [`CPI_IRQ_W-1:0] irq_set;
  logic [`CPI_IRQ_W-1:0] irq_clr;

  assign op = s.instr[7:0];
  assign b1 = s.instr[15:8];
  assign b2 = s.instr[23:16];
  // Displacement high byte first; the location register holds the operand byte address.
  assign disp = {b1, b2};
  assign stk_top_m1 = s.stk_top - 8'h01;
  assign apb_wr = psel && penable && s.pready && pwrite;
  // A halted unit ignores starts until software resumes it.
  assign go = apb_wr && (paddr == `CPI_A_CTRL) && pwdata[`CPI_CTRL_GO] &&
    (s.busy == 8'h00) && !s.halted;
  assign ls_ra = (psel && penable && op == `CPI_OP_INC_LS) ? LS_AW'({lt_rd[7:0], s.idx}) :
    s.lsaddr[LS_AW-1:0];

  // Read ports: 0 named entry, 1 entry at index_hold, 2 named entry plus one, 3 window.
  cpi_regfile #(.W(8), .AW(LT_AW), .NRD(4)) u_line_table (
    .pclk(pclk),
    .presetn(presetn),
    .we(lt_we),
    .waddr(lt_wa),
    .wdata(lt_wd),
    .clr(lt_clr),
    .raddr({s.taddr[LT_AW-1:0], LT_AW'(b1 + 8'h01), s.idx[LT_AW-1:0], b1[LT_AW-1:0]}),
    .rdata(lt_rd)
  );

  cpi_regfile #(.W(8), .AW(LS_AW), .NRD(1)) u_local_store (
    .pclk(pclk),
    .presetn(presetn),
    .we(ls_we),
    .waddr(ls_wa),
    .wdata(ls_wd),
    .clr('0),
    .raddr(ls_ra),
    .rdata(ls_rd)
  );

  cpi_regfile #(.W(16), .AW(STK_AW), .NRD(1)) u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .we(stk_we),
    .waddr(stk_top_m1[STK_AW-1:0]),
    .wdata(stk_wd),
    .clr('0),
    .raddr(s.stk_top[STK_AW-1:0]),
    .rdata(stk_rd)
  );

  cpi_alu8 #(.W(8)) u_alu (
    .a(alu_a),
    .b(alu_b),
    .op_and(alu_and),
    .res(alu_res),
    .carry(alu_c),
    .top(alu_top),
    .zero(alu_z)
  );

  // --------------------------------------------------------------------------
  // Operand selection
  // --------------------------------------------------------------------------
  always_comb begin
    alu_and = (op == `CPI_OP_BIT_TBL) || (op == `CPI_OP_BIT_IDX);
    alu_b = (op == `CPI_OP_BIT_TBL) ? b2 : b1;
    unique case (op)
      `CPI_OP_INC_TBL, `CPI_OP_BIT_TBL: alu_a = lt_rd[7:0];
      `CPI_OP_INC_IDX, `CPI_OP_BIT_IDX: alu_a = lt_rd[15:8];
      `CPI_OP_INC_B: alu_a = s.idx;
      `CPI_OP_INC_LS: alu_a = ls_rd;
      default: alu_a = s.acc;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    n = s;
    lt_we = 1'b0;
    lt_wa = b1[LT_AW-1:0];
    lt_wd = alu_res;
    lt_clr = '0;
    ls_we = 1'b0;
    ls_wa = ls_ra;
    ls_wd = alu_res;
    stk_we = 1'b0;
    stk_wd = s.ip + 16'h0001;
    irq_set = '0;
    irq_clr = '0;
    n.adp_clr = 1'b0;
    n.pready = psel && !penable;
    n.pslverr = psel && !penable && !mapped(paddr);
    if (s.busy != 8'h00) begin
      n.busy = s.busy - 8'h01;
      if (s.busy == 8'h01) begin
        irq_set[`CPI_IRQ_DONE] = 1'b1;
      end
    end
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `CPI_A_CTRL: n.prdata = 32'h00000000;
        `CPI_A_INSTR: n.prdata = {8'h00, s.instr};
        `CPI_A_STATUS: n.prdata = {26'h0, s.halted, s.busy != 8'h00, 1'b0, s.fc, s.fsb, s.fz};
        `CPI_A_ACC: n.prdata = {16'h0000, s.idx, s.acc};
        `CPI_A_IP: n.prdata = {16'h0000, s.ip};
        `CPI_A_STACK: n.prdata = {stk_rd, 8'h00, s.stk_top};
        `CPI_A_IRQ_STAT: n.prdata = {29'h0, s.stat};
        `CPI_A_IRQ_MASK: n.prdata = {29'h0, s.mask};
        `CPI_A_LEVEL: n.prdata = {24'h0, s.level};
        `CPI_A_CFGA: n.prdata = {24'h0, s.cfga};
        `CPI_A_TADDR: n.prdata = {24'h0, s.taddr};
        `CPI_A_TDATA: n.prdata = {24'h0, lt_rd[31:24]};
        `CPI_A_LSADDR: n.prdata = {16'h0000, s.lsaddr};
        `CPI_A_LSDATA: n.prdata = {24'h0, ls_rd};
        default: n.prdata = 32'h00000000;
      endcase
    end
    if (apb_wr) begin
      unique case (paddr)
        `CPI_A_CTRL: n.halted = s.halted && !pwdata[`CPI_CTRL_RESUME];
        `CPI_A_INSTR: n.instr = pwdata[23:0];
        `CPI_A_ACC: begin
          n.acc = pwdata[7:0];
          n.idx = pwdata[15:8];
        end
        `CPI_A_IP: n.ip = pwdata[15:0];
        `CPI_A_STACK: n.stk_top = pwdata[7:0];
        `CPI_A_IRQ_STAT: irq_clr = pwdata[`CPI_IRQ_W-1:0];
        `CPI_A_IRQ_MASK: n.mask = pwdata[`CPI_IRQ_W-1:0];
        `CPI_A_LEVEL: n.level = pwdata[7:0];
        `CPI_A_CFGA: n.cfga = pwdata[7:0];
        `CPI_A_TADDR: n.taddr = pwdata[7:0];
        `CPI_A_TDATA: begin
          lt_we = 1'b1;
          lt_wa = s.taddr[LT_AW-1:0];
          lt_wd = pwdata[7:0];
        end
        `CPI_A_LSADDR: n.lsaddr = pwdata[15:0];
        `CPI_A_LSDATA: begin
          ls_we = 1'b1;
          ls_wa = s.lsaddr[LS_AW-1:0];
          ls_wd = pwdata[7:0];
        end
        default: n.acc = s.acc;
      endcase
    end
    if (go) begin
      n.busy = op_cycles(op);
      unique case (op)
        `CPI_OP_INC_TBL, `CPI_OP_INC_IDX: begin
          lt_we = 1'b1;
          lt_wa = (op == `CPI_OP_INC_IDX) ? s.idx[LT_AW-1:0] : b1[LT_AW-1:0];
          {n.fc, n.fsb, n.fz} = {alu_c, alu_top, alu_z};
        end
        `CPI_OP_INC_ACC, `CPI_OP_INC_B: begin
          n.acc = (op == `CPI_OP_INC_ACC) ? alu_res : s.acc;
          n.idx = (op == `CPI_OP_INC_B) ? alu_res : s.idx;
          {n.fc, n.fsb, n.fz} = {alu_c, alu_top, alu_z};
        end
        `CPI_OP_INC_LS: begin
          if (s.cfga[`CPI_CFGA_LS_EN]) begin
            ls_we = 1'b1;
            {n.fc, n.fsb, n.fz} = {alu_c, alu_top, alu_z};
          end else begin
            irq_set[`CPI_IRQ_ILLEGAL] = 1'b1;
          end
        end
        `CPI_OP_HOST_INT: begin
          irq_set[`CPI_IRQ_HOST] = (s.level != `CPI_RST_BYTE);
        end
        `CPI_OP_SOFT_CLR: begin
          n.acc = `CPI_RST_BYTE;
          n.idx = `CPI_RST_BYTE;
          n.ip = `CPI_RST_WORD;
          n.stk_top = `CPI_RST_BYTE;
          {n.fc, n.fsb, n.fz} = 3'h0;
          lt_clr[`CPI_LT_SCAN_RX] = 1'b1;
          lt_clr[`CPI_LT_FW_RX] = 1'b1;
          lt_clr[`CPI_LT_SCAN_TX] = 1'b1;
          lt_clr[`CPI_LT_FW_TX] = 1'b1;
          n.adp_clr = 1'b1;
          n.halted = 1'b1;
        end
        `CPI_OP_CALL_REL, `CPI_OP_CALL_VEC: begin
          stk_we = 1'b1;
          n.stk_top = s.stk_top - 8'h02;
          n.ip = (op == `CPI_OP_CALL_REL) ? s.ip + disp : {lt_rd[7:0], lt_rd[23:16]};
        end
        `CPI_OP_JUMP_REL: n.ip = s.ip + disp;
        `CPI_OP_JUMP_VEC: n.ip = {lt_rd[7:0], lt_rd[23:16]};
        `CPI_OP_BIT_TBL, `CPI_OP_BIT_IDX: begin
          {n.fsb, n.fz} = {alu_top, alu_z};
        end
        default: irq_set[`CPI_IRQ_ILLEGAL] = 1'b1;
      endcase
    end
    // A hardware event in the cycle of its clear keeps the bit set.
    n.stat = (s.stat & ~irq_clr) | irq_set;
    n.host_irq = |(n.stat & n.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign host_irq = s.host_irq;
  assign adapter_clear = s.adp_clr;
  assign lines_stopped = s.halted;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_acc_inc_value: assert property (go && op == `CPI_OP_INC_ACC |=>
    s.acc == $past(s.acc) + 8'h01) else $error("accumulator increment wrong");
  chk_acc_inc_time: assert property (go && op == `CPI_OP_INC_ACC |=>
    (s.busy != 8'h00)[*8] ##1 s.busy == 8'h00) else $error("increment time wrong");
  chk_idx_inc_value: assert property (go && op == `CPI_OP_INC_B |=>
    s.idx == $past(s.idx) + 8'h01 && s.busy == 8'h08) else $error("index increment wrong");
  chk_wrap_flags: assert property (go && op == `CPI_OP_INC_ACC && s.acc == 8'hFF |=>
    s.acc == 8'h00 && s.fc && s.fz && !s.fsb) else $error("wrap flags wrong");
  chk_ls_illegal: assert property (go && op == `CPI_OP_INC_LS &&
    !s.cfga[`CPI_CFGA_LS_EN] |=> s.stat[`CPI_IRQ_ILLEGAL] && $stable({s.fc, s.fsb, s.fz}))
    else $error("local store gate wrong");
  chk_host_int: assert property (go && op == `CPI_OP_HOST_INT && s.level != 8'h00 |=>
    s.stat[`CPI_IRQ_HOST] && $stable({s.fc, s.fsb, s.fz})) else $error("host interrupt lost");
  chk_soft_clear: assert property (go && op == `CPI_OP_SOFT_CLR |=>
    adapter_clear && lines_stopped && s.acc == 8'h00 ##1 !adapter_clear)
    else $error("soft clear wrong");
  chk_halt_holds: assert property (lines_stopped && !(apb_wr && paddr == `CPI_A_CTRL) |=>
    lines_stopped && !go) else $error("halted unit ran");
  chk_call_rel: assert property (go && op == `CPI_OP_CALL_REL |=>
    s.stk_top == $past(s.stk_top) - 8'h02 && s.ip == $past(s.ip) + $past(disp))
    else $error("relative call wrong");
  chk_jump_rel: assert property (go && op == `CPI_OP_JUMP_REL |=>
    s.ip == $past(s.ip) + $past(disp) && $stable(s.stk_top) && $stable({s.fc, s.fsb, s.fz}))
    else $error("relative jump wrong");
  chk_bit_idx: assert property (go && op == `CPI_OP_BIT_IDX |=>
    s.fz == (($past(lt_rd[15:8]) & $past(b1)) == 8'h00) && $stable(s.fc) && s.busy == 8'h05)
    else $error("indexed bit test wrong");
  chk_irq_level: assert property (host_irq == |(s.stat & s.mask))
    else $error("interrupt output wrong");

  cov_wrap: cover property (go && op == `CPI_OP_INC_ACC && s.acc == 8'hFF);
  cov_call_vec: cover property (go && op == `CPI_OP_CALL_VEC);
  cov_soft_clear: cover property (go && op == `CPI_OP_SOFT_CLR);
  cov_ls_inc: cover property (go && op == `CPI_OP_INC_LS && s.cfga[`CPI_CFGA_LS_EN]);

endmodule // cpi_core

// ===== core/cpi_cfg.svh
/*
  Constants of the channel program instruction block: opcodes, register offsets, bit
  positions, reset values and instruction times. Assumes a 50 ns pclk.
*/
`ifndef CPI_CFG_SVH
`define CPI_CFG_SVH

// ----------------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------------
`define CPI_OP_INC_TBL 8'h5D
`define CPI_OP_INC_IDX 8'h8D
`define CPI_OP_INC_ACC 8'h9D
`define CPI_OP_INC_B 8'hBD
`define CPI_OP_INC_LS 8'hCD
`define CPI_OP_HOST_INT 8'h08
`define CPI_OP_SOFT_CLR 8'h90
`define CPI_OP_CALL_REL 8'hF6
`define CPI_OP_CALL_VEC 8'hF8
`define CPI_OP_JUMP_REL 8'hE6
`define CPI_OP_JUMP_VEC 8'hE8
`define CPI_OP_BIT_TBL 8'h77
`define CPI_OP_BIT_IDX 8'h87

// ----------------------------------------------------------------------------
// APB register byte offsets
// ----------------------------------------------------------------------------
`define CPI_A_CTRL 8'h00
`define CPI_A_INSTR 8'h04
`define CPI_A_STATUS 8'h08
`define CPI_A_ACC 8'h0C
`define CPI_A_IP 8'h10
`define CPI_A_STACK 8'h14
`define CPI_A_IRQ_STAT 8'h18
`define CPI_A_IRQ_MASK 8'h1C
`define CPI_A_LEVEL 8'h20
`define CPI_A_CFGA 8'h24
`define CPI_A_TADDR 8'h28
`define CPI_A_TDATA 8'h2C
`define CPI_A_LSADDR 8'h30
`define CPI_A_LSDATA 8'h34

// ----------------------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------------------
`define CPI_CTRL_GO 0
`define CPI_CTRL_RESUME 1
`define CPI_CFGA_LS_EN 4
`define CPI_IRQ_HOST 0
`define CPI_IRQ_ILLEGAL 1
`define CPI_IRQ_DONE 2
`define CPI_IRQ_W 3
`define CPI_LT_SCAN_RX 8
`define CPI_LT_FW_RX 9
`define CPI_LT_SCAN_TX 40
`define CPI_LT_FW_TX 41

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CPI_RST_BYTE 8'h00
`define CPI_RST_WORD 16'h0000
`define CPI_RST_MASK 3'h0

// ----------------------------------------------------------------------------
// Instruction times in ns and their cycle counts, rounded up
// ----------------------------------------------------------------------------
`define CPI_CLK_NS 50
`define CPI_T_INC_TBL_NS 380
`define CPI_T_INC_IDX_NS 1000
`define CPI_T_INC_ACC_NS 380
`define CPI_T_INC_LS_NS 7000
`define CPI_T_CALL_REL_NS 6200
`define CPI_T_JUMP_REL_NS 3000
`define CPI_T_BIT_TBL_NS 1200
`define CPI_T_BIT_IDX_NS 250
`define CPI_T_OTHER_NS 50
`define CPI_CYC(ns) (8'(((ns) + `CPI_CLK_NS - 1) / `CPI_CLK_NS))

`endif

// ===== core/cpi_pkg.sv
/*
  Types of the channel program instruction block. Assumes cpi_cfg.svh beside it.
*/
`include "cpi_cfg.svh"

package cpi_pkg;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] idx;
    logic [15:0] ip;
    logic [7:0] stk_top;
    logic fc;
    logic fsb;
    logic fz;
    logic [7:0] busy;
    logic halted;
    logic [7:0] cfga;
    logic [7:0] level;
    logic [23:0] instr;
    logic [`CPI_IRQ_W-1:0] stat;
    logic [`CPI_IRQ_W-1:0] mask;
    logic [7:0] taddr;
    logic [15:0] lsaddr;
    logic adp_clr;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic host_irq;
  } cpi_state_t;

endpackage

// ===== core/cpi_alu8.sv
/*
  Byte incrementer and bit tester with carry, top bit and zero results.
  Purely combinational; the caller registers whatever it keeps.
*/
`timescale 1ns/1ps

module cpi_alu8 #(
  parameter int W = 8
) (
  // Operands
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic op_and,
  // Results
  output logic [W-1:0] res,
  output logic carry,
  output logic top,
  output logic zero
);

  always_comb begin
    if (op_and) begin
      res = a & b;
      carry = 1'b0;
    end else begin
      {carry, res} = {1'b0, a} + {{W{1'b0}}, 1'b1};
    end
    top = res[W-1];
    zero = (res == '0);
  end

endmodule // cpi_alu8

// ===== core/cpi_regfile.sv
/*
  Flip-flop storage with one write port, several read ports and a per-entry clear.
  Clear wins over a write to the same entry.
*/
`timescale 1ns/1ps

module cpi_regfile #(
  parameter int W = 8,
  parameter int AW = 6,
  parameter int NRD = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [(1<<AW)-1:0] clr,
  // Read ports
  input wire logic [NRD*AW-1:0] raddr,
  output logic [NRD*W-1:0] rdata
);

  logic [W-1:0] mem [1<<AW];
  logic [W-1:0] next_mem [1<<AW];

  always_comb begin
    next_mem = mem;
    if (we) begin
      next_mem[waddr] = wdata;
    end
    for (int i = 0; i < (1 << AW); i++) begin
      if (clr[i]) begin
        next_mem[i] = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < (1 << AW); i++) begin
        mem[i] <= '0;
      end
    end else begin
      mem <= next_mem;
    end
  end

  for (genvar g = 0; g < NRD; g++) begin : g_rd
    assign rdata[g*W +: W] = mem[raddr[g*AW +: AW]];
  end

endmodule // cpi_regfile

// ===== verif/cpi_host_model.sv
/*
  Host CPU stand-in that counts the interrupt requests it receives.
  Assumes the block's pclk and presetn.
*/
`timescale 1ns/1ps

module cpi_host_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Interrupt line
  input wire logic host_irq,
  output int irq_seen
);
  logic prev;

  // A level request is counted once, on its rising edge, as a host would latch it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 1'b0;
      irq_seen <= 0;
    end else begin
      prev <= host_irq;
      if (host_irq && !prev) begin
        irq_seen <= irq_seen + 1;
      end
    end
  end
endmodule // cpi_host_model

// ===== verif/cpi_core_tb.sv
/*
  Self-checking bench for cpi_core: APB master tasks and one task per scenario.
  Assumes the core's default parameters and one-cycle APB answers.
*/
`timescale 1ns/1ps
`include "cpi_cfg.svh"

module cpi_core_tb;
  import cpi_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic host_irq;
  logic adapter_clear;
  logic lines_stopped;
  int irq_seen;
  int num_errors = 0;
  int tests_run = 0;
  logic [31:0] rv;
  logic ev;

  always #25 pclk = ~pclk;

  cpi_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host_irq(host_irq), .adapter_clear(adapter_clear),
    .lines_stopped(lines_stopped));
  cpi_host_model host (.pclk(pclk), .presetn(presetn), .host_irq(host_irq),
    .irq_seen(irq_seen));

  // ----------------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------------
  task automatic end_sim();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One idle cycle follows each transfer so no signal is driven twice in a step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rv = prdata;
    ev = pslverr;
    if (n >= 20) begin
      num_errors++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv & m, exp);
  endtask

  // Runs one instruction, waits for its done status, returns the status and clears its done and illegal bits.
  // A refused instruction still counts down, so the next start waits for done too.
  task automatic exec(input logic [23:0] w, output logic [31:0] st);
    int n;
    apb(1'b1, `CPI_A_INSTR, {8'h00, w});
    apb(1'b1, `CPI_A_CTRL, 32'h1);
    n = 0;
    do begin
      apb(1'b0, `CPI_A_IRQ_STAT, 32'h0);
      n++;
    end while ((rv & 32'h4) == 32'h0 && n < 100);
    st = rv;
    if (n >= 100) begin
      num_errors++;
      end_sim();
    end
    apb(1'b1, `CPI_A_IRQ_STAT, 32'h6);
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_incs();
    logic [31:0] st;
    apb(1'b1, `CPI_A_ACC, 32'h00FF);
    exec(24'h00009D, st);
    rdchk(`CPI_A_ACC, 32'hFF, 32'h00);
    rdchk(`CPI_A_STATUS, 32'h3F, 32'h05);
    apb(1'b1, `CPI_A_TADDR, 32'd5);
    apb(1'b1, `CPI_A_TDATA, 32'h7F);
    exec(24'h00055D, st);
    rdchk(`CPI_A_TDATA, 32'hFF, 32'h80);
    rdchk(`CPI_A_STATUS, 32'h07, 32'h02);
  endtask

  task automatic t_bittest();
    logic [31:0] st;
    apb(1'b1, `CPI_A_ACC, 32'h00FF);
    exec(24'h00009D, st);
    apb(1'b1, `CPI_A_TADDR, 32'd60);
    apb(1'b1, `CPI_A_TDATA, 32'hC5);
    exec(24'h963C77, st);
    rdchk(`CPI_A_STATUS, 32'h07, 32'h06);
    rdchk(`CPI_A_TDATA, 32'hFF, 32'hC5);
  endtask

  task automatic t_call();
    logic [31:0] st;
    apb(1'b1, `CPI_A_IP, 32'h0100);
    apb(1'b1, `CPI_A_STACK, 32'h10);
    exec(24'hF0FFF6, st);
    rdchk(`CPI_A_IP, 32'hFFFF, 32'h00F0);
    rdchk(`CPI_A_STACK, 32'hFF, 32'h0E);
    rdchk(`CPI_A_STATUS, 32'h07, 32'h06);
  endtask

  task automatic t_jump();
    logic [31:0] st;
    apb(1'b1, `CPI_A_ACC, 32'h0500);
    exec(24'h00008D, st);
    exec(24'h0000BD, st);
    rdchk(`CPI_A_ACC, 32'hFFFF, 32'h0600);
    rdchk(`CPI_A_STATUS, 32'h07, 32'h00);
    apb(1'b1, `CPI_A_TADDR, 32'd5);
    rdchk(`CPI_A_TDATA, 32'hFF, 32'h81);
    apb(1'b1, `CPI_A_TADDR, 32'd6);
    apb(1'b1, `CPI_A_TDATA, 32'h0F);
    exec(24'h00F087, st);
    rdchk(`CPI_A_STATUS, 32'h07, 32'h01);
    rdchk(`CPI_A_TDATA, 32'hFF, 32'h0F);
    apb(1'b1, `CPI_A_IP, 32'h0200);
    apb(1'b1, `CPI_A_STACK, 32'h08);
    exec(24'h0005F8, st);
    rdchk(`CPI_A_IP, 32'hFFFF, 32'h810F);
    rdchk(`CPI_A_STACK, 32'hFF, 32'h06);
    rdchk(`CPI_A_STATUS, 32'h07, 32'h01);
    apb(1'b1, `CPI_A_STACK, 32'h07);
    rdchk(`CPI_A_STACK, 32'hFFFF0000, 32'h02010000);
    apb(1'b1, `CPI_A_IP, 32'h0);
    exec(24'h0005E8, st);
    rdchk(`CPI_A_IP, 32'hFFFF, 32'h810F);
    exec(24'h00FFE6, st);
    rdchk(`CPI_A_IP, 32'hFFFF, 32'h800F);
    rdchk(`CPI_A_STACK, 32'hFF, 32'h07);
    rdchk(`CPI_A_STATUS, 32'h07, 32'h01);
  endtask

  task automatic t_host();
    logic [31:0] st;
    apb(1'b1, `CPI_A_IRQ_MASK, 32'h1);
    apb(1'b1, `CPI_A_LEVEL, 32'h0);
    exec(24'h000008, st);
    chk({31'h0, host_irq}, 32'h0);
    apb(1'b1, `CPI_A_LEVEL, 32'h1);
    exec(24'h000008, st);
    chk({31'h0, host_irq}, 32'h1);
    chk(irq_seen, 32'd1);
    apb(1'b1, `CPI_A_IRQ_STAT, 32'h1);
    apb(1'b1, `CPI_A_IRQ_MASK, 32'h0);
    chk({31'h0, host_irq}, 32'h0);
  endtask

  task automatic t_local();
    logic [31:0] st;
    apb(1'b1, `CPI_A_CFGA, 32'h00);
    exec(24'h0003CD, st);
    chk(st & 32'h2, 32'h2);
    apb(1'b1, `CPI_A_CFGA, 32'h10);
    apb(1'b1, `CPI_A_ACC, 32'h2000);
    apb(1'b1, `CPI_A_TADDR, 32'd3);
    apb(1'b1, `CPI_A_TDATA, 32'h01);
    apb(1'b1, `CPI_A_LSADDR, 32'h120);
    apb(1'b1, `CPI_A_LSDATA, 32'hFF);
    exec(24'h0003CD, st);
    rdchk(`CPI_A_LSDATA, 32'hFF, 32'h00);
  endtask

  task automatic t_clear();
    logic [31:0] st;
    apb(1'b1, `CPI_A_TADDR, 32'd8);
    apb(1'b1, `CPI_A_TDATA, 32'h55);
    apb(1'b1, `CPI_A_ACC, 32'h1234);
    exec(24'h000090, st);
    chk({31'h0, lines_stopped}, 32'h1);
    rdchk(`CPI_A_ACC, 32'hFFFF, 32'h0);
    apb(1'b1, `CPI_A_TADDR, 32'd8);
    rdchk(`CPI_A_TDATA, 32'hFF, 32'h0);
    apb(1'b1, `CPI_A_CTRL, 32'h2);
    chk({31'h0, lines_stopped}, 32'h0);
    apb(1'b0, 8'h38, 32'h0);
    chk({31'h0, ev}, 32'h1);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(`CPI_A_STATUS, 32'hFFFFFFFF, 32'h0);
    t_incs();
    t_bittest();
    t_call();
    t_jump();
    t_host();
    t_local();
    t_clear();
    end_sim();
  end
endmodule // cpi_core_tb
